// ---- core/scan_timing.sv ----
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module scan_timing
  import scan_timing_pkg::*;
#(
  parameter int SWEEP_W = 16
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // radar triggers and operator control (asynchronous pins)
  input wire logic trig_fwd,
  input wire logic trig_bwd,
  input wire logic line_shift_on,
  // timing outputs
  output logic [SWEEP_W-1:0] sweep_level,
  output logic scan_end_pulse,
  output logic interscan_range_blank_pulse,
  output logic interscan_begin_pulse,
  output logic timebase_start_pulse,
  output logic brill_start_pulse,
  output logic timebase_gate,
  output logic timebase_gate_n,
  output logic brill_enable_n,
  output logic main_scan_sw,
  output logic inter_scan_sw,
  output logic main_scan_shift,
  output logic inter_scan_shift
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SWEEP_W < 8 || SWEEP_W > 16)
  begin : g_bad_width
    $error("SWEEP_W must lie between 8 and 16");
  end

  localparam int LEAD = TB_LEAD_CYC;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fwd1;
    logic fwd2;
    logic bwd1;
    logic bwd2;
    logic ls1;
    logic ls2;
    logic trig_inv_d;
    logic gate;
    logic [SWEEP_W-1:0] cnt;
    logic [3:0][SWEEP_W-1:0] max_rng;
    logic [1:0] rng_sel;
    logic [SWEEP_W-1:0] blank_rng;
    logic [6:0] ratio;
    logic [6:0] tmr;
    logic [11:0] tb_dly;
    logic [11:0] d1;
    logic [11:0] d2;
    logic tb;
    logic br;
    logic scan_sw;
    logic shift_sw;
    logic se;
    logic bl;
    logic bg;
    logic tbs;
    logic cs;
    logic ack;
    logic [31:0] dat;
  } state_t;

  state_t q_r;
  state_t q_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  logic trig_evt;
  logic hit;
  logic blank_hit;
  logic fall;
  logic begin_ev;
  logic tb_start;
  logic cal_start;
  logic req;
  logic [SWEEP_W-1:0] thr;
  logic [31:0] wv;
  logic [31:0] rd;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    q_nxt = q_r;
    // two-flop synchronisers; only the second stage is read
    q_nxt.fwd1 = trig_fwd;
    q_nxt.fwd2 = q_r.fwd1;
    q_nxt.bwd1 = trig_bwd;
    q_nxt.bwd2 = q_r.bwd1;
    q_nxt.ls1 = line_shift_on;
    q_nxt.ls2 = q_r.ls1;
    q_nxt.trig_inv_d = ~(q_r.fwd2 | q_r.bwd2);
    // falling edge of the inverted stream is the trigger event
    trig_evt = q_r.trig_inv_d & (q_r.fwd2 | q_r.bwd2);

    thr = q_r.max_rng[q_r.rng_sel];
    hit = q_r.gate && (q_r.cnt == thr);
    blank_hit = q_r.gate && q_r.scan_sw && (q_r.cnt == q_r.blank_rng);

    // sweep gate
    // a trigger on an open gate ends the sweep, so a gate left open at power-up clears
    if (trig_evt)
    begin
      q_nxt.gate = ~q_r.gate;
    end
    else if (hit)
    begin
      q_nxt.gate = 1'b0;
    end
    q_nxt.cnt = q_r.gate ? q_r.cnt + 1'b1 : '0;
    fall = q_r.gate & ~q_nxt.gate;

    // interscan ratio timer
    begin_ev = fall && (q_r.tmr == 7'h00);
    if (begin_ev)
    begin
      q_nxt.tmr = q_r.ratio;
    end
    else if (fall)
    begin
      q_nxt.tmr = q_r.tmr - 7'h01;
    end

    // switch bistables: set checked before the fall clear so it wins, but line shift off clears the shift switch first
    if (begin_ev)
    begin
      q_nxt.scan_sw = 1'b1;
    end
    else if (fall)
    begin
      q_nxt.scan_sw = 1'b0;
    end
    if (!q_r.ls2)
    begin
      q_nxt.shift_sw = 1'b0;
    end
    else if (begin_ev)
    begin
      q_nxt.shift_sw = 1'b1;
    end
    else if (fall)
    begin
      q_nxt.shift_sw = 1'b0;
    end

    // delay chain
    tb_start = (q_r.d1 == 12'h001);
    cal_start = (q_r.d2 == 12'h001);
    if (trig_evt)
    begin
      q_nxt.d1 = (q_r.tb_dly == 12'h000) ? 12'h001 : q_r.tb_dly;
    end
    else if (q_r.d1 != 12'h000)
    begin
      q_nxt.d1 = q_r.d1 - 12'h001;
    end
    if (tb_start)
    begin
      q_nxt.d2 = 12'(TB_LEAD_CYC);
    end
    else if (q_r.d2 != 12'h000)
    begin
      q_nxt.d2 = q_r.d2 - 12'h001;
    end

    // gates
    if (tb_start)
    begin
      q_nxt.tb = 1'b1;
    end
    else if (hit)
    begin
      q_nxt.tb = 1'b0;
    end
    if (cal_start)
    begin
      q_nxt.br = 1'b1;
    end
    else if (hit || blank_hit)
    begin
      q_nxt.br = 1'b0;
    end

    q_nxt.se = hit;
    q_nxt.bl = blank_hit;
    q_nxt.bg = begin_ev;
    q_nxt.tbs = tb_start;
    q_nxt.cs = cal_start;

    // wishbone: ack one cycle after request, write at the ack edge
    req = wb_cyc_i & wb_stb_i;
    q_nxt.ack = req & ~q_r.ack;
    rd = 32'h0000_0000;
    case (wb_adr_i)
      OFS_CTRL: rd[CTRL_SEL_LSB +: 2] = q_r.rng_sel;
      OFS_MAX_RANGE0: rd[SWEEP_W-1:0] = q_r.max_rng[0];
      OFS_MAX_RANGE1: rd[SWEEP_W-1:0] = q_r.max_rng[1];
      OFS_MAX_RANGE2: rd[SWEEP_W-1:0] = q_r.max_rng[2];
      OFS_MAX_RANGE3: rd[SWEEP_W-1:0] = q_r.max_rng[3];
      OFS_BLANK_RANGE: rd[SWEEP_W-1:0] = q_r.blank_rng;
      OFS_RATIO: rd[6:0] = q_r.ratio;
      OFS_TB_DELAY: rd[11:0] = q_r.tb_dly;
      OFS_STATUS:
      begin
        rd[ST_SWEEP_GATE] = q_r.gate;
        rd[ST_TB_GATE] = q_r.tb;
        rd[ST_BRILL_GATE] = q_r.br;
        rd[ST_SCAN_SW] = q_r.scan_sw;
        rd[ST_SHIFT_SW] = q_r.shift_sw;
        rd[ST_LINE_SHIFT] = q_r.ls2;
        rd[ST_TIMER_LSB +: 7] = q_r.tmr;
      end
      OFS_SWEEP: rd[SWEEP_W-1:0] = q_r.cnt;
      default: rd = 32'h0000_0000;
    endcase
    if (req && !q_r.ack)
    begin
      q_nxt.dat = rd;
    end
    wv = merge(rd, wb_dat_i, wb_sel_i);
    if (req && q_r.ack && wb_we_i)
    begin
      case (wb_adr_i)
        OFS_CTRL: q_nxt.rng_sel = wv[CTRL_SEL_LSB +: 2];
        OFS_MAX_RANGE0: q_nxt.max_rng[0] = wv[SWEEP_W-1:0];
        OFS_MAX_RANGE1: q_nxt.max_rng[1] = wv[SWEEP_W-1:0];
        OFS_MAX_RANGE2: q_nxt.max_rng[2] = wv[SWEEP_W-1:0];
        OFS_MAX_RANGE3: q_nxt.max_rng[3] = wv[SWEEP_W-1:0];
        OFS_BLANK_RANGE: q_nxt.blank_rng = wv[SWEEP_W-1:0];
        OFS_RATIO:
        begin
          // hold-off outside 15..100 periods is clamped, not refused
          if (wv[6:0] < RATIO_MIN || wv[31:7] != 25'h0)
          begin
            q_nxt.ratio = (wv[31:7] != 25'h0) ? RATIO_MAX : RATIO_MIN;
          end
          else if (wv[6:0] > RATIO_MAX)
          begin
            q_nxt.ratio = RATIO_MAX;
          end
          else
          begin
            q_nxt.ratio = wv[6:0];
          end
        end
        OFS_TB_DELAY: q_nxt.tb_dly = wv[11:0];
        default: q_nxt.rng_sel = q_r.rng_sel;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q_r <= '0;
      q_r.trig_inv_d <= 1'b1;
      q_r.max_rng <= {4{SWEEP_W'(MAX_RANGE_DEF)}};
      q_r.blank_rng <= SWEEP_W'(BLANK_RANGE_DEF);
      q_r.ratio <= RATIO_DEF;
      q_r.tb_dly <= 12'(TB_DELAY_DEF_CYC);
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = q_r.ack;
  assign wb_dat_o = q_r.dat;
  assign sweep_level = q_r.cnt;
  assign scan_end_pulse = q_r.se;
  assign interscan_range_blank_pulse = q_r.bl;
  assign interscan_begin_pulse = q_r.bg;
  assign timebase_start_pulse = q_r.tbs;
  assign brill_start_pulse = q_r.cs;
  assign timebase_gate = q_r.tb;
  assign timebase_gate_n = ~q_r.tb;
  assign brill_enable_n = ~q_r.br;
  assign inter_scan_sw = q_r.scan_sw;
  assign main_scan_sw = ~q_r.scan_sw;
  assign inter_scan_shift = q_r.shift_sw;
  assign main_scan_shift = ~q_r.shift_sw;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  gate_ends_a: assert property (scan_end_pulse |-> !q_r.gate ##1 sweep_level == '0) else $error("gate open after scan end");
  trig_start_a: assert property (trig_evt && !q_r.gate |=> q_r.gate ##1 sweep_level == 1) else $error("trigger did not start sweep");
  trig_end_a: assert property (trig_evt && q_r.gate |=> !q_r.gate ##1 sweep_level == 0) else $error("trigger did not end open gate");
  sweep_zero_a: assert property (!q_r.gate |=> sweep_level == 0) else $error("sweep not held");
  scan_end_a: assert property (q_r.gate && sweep_level == thr |=> scan_end_pulse && !timebase_gate) else $error("no scan end at max range");
  blank_en_a: assert property (interscan_range_blank_pulse && !brill_start_pulse |-> $past(inter_scan_sw) && brill_enable_n) else $error("blank outside interscan");
  delay_lead_a: assert property (timebase_start_pulse |-> ##LEAD brill_start_pulse) else $error("brilliance start not 0.75 us after timebase start");
  tb_gate_a: assert property (timebase_start_pulse |-> timebase_gate && !timebase_gate_n) else $error("timebase gate not set");
  set_wins_a: assert property (interscan_begin_pulse |-> inter_scan_sw && !q_r.gate) else $error("begin pulse lost to clear");
  holdoff_a: assert property (interscan_begin_pulse |-> q_r.tmr == $past(q_r.ratio) && q_r.tmr >= RATIO_MIN) else $error("timer not loaded");
  shift_off_a: assert property (!q_r.ls2 |=> !inter_scan_shift && main_scan_shift) else $error("shift switch left interscan");

  begin_c: cover property (interscan_begin_pulse);
  blank_c: cover property (interscan_range_blank_pulse ##[1:1000] scan_end_pulse);
  shift_c: cover property (interscan_begin_pulse && inter_scan_shift);
  cut_c: cover property (trig_evt && q_r.gate);

endmodule : scan_timing

// ---- core/scan_timing_pkg.sv ----
package scan_timing_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MAX_RANGE0 = 8'h04;
  localparam logic [7:0] OFS_MAX_RANGE1 = 8'h08;
  localparam logic [7:0] OFS_MAX_RANGE2 = 8'h0C;
  localparam logic [7:0] OFS_MAX_RANGE3 = 8'h10;
  localparam logic [7:0] OFS_BLANK_RANGE = 8'h14;
  localparam logic [7:0] OFS_RATIO = 8'h18;
  localparam logic [7:0] OFS_TB_DELAY = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_SWEEP = 8'h24;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SEL_LSB = 0;
  localparam int ST_SWEEP_GATE = 0;
  localparam int ST_TB_GATE = 1;
  localparam int ST_BRILL_GATE = 2;
  localparam int ST_SCAN_SW = 3;
  localparam int ST_SHIFT_SW = 4;
  localparam int ST_LINE_SHIFT = 5;
  localparam int ST_TIMER_LSB = 8;

  // ----------------------------------------------------------------
  // reset values and ratio limits
  // ----------------------------------------------------------------
  localparam logic [15:0] MAX_RANGE_DEF = 16'h03E8;
  localparam logic [15:0] BLANK_RANGE_DEF = 16'h01F4;
  localparam logic [6:0] RATIO_MIN = 7'h0F;
  localparam logic [6:0] RATIO_MAX = 7'h64;
  localparam logic [6:0] RATIO_DEF = 7'h0F;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int TB_LEAD_NS = 750;
  localparam int TRIG_EARLY_NS = 1000;
  // least time: round up to whole cycles
  localparam int TB_LEAD_CYC = (TB_LEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int TB_DELAY_DEF_CYC = ((TRIG_EARLY_NS - TB_LEAD_NS) * CLK_MHZ + 999) / 1000;

endpackage : scan_timing_pkg

// ---- verif/radar_trig_src.sv ----
`timescale 1ns/10ps
// ------
// radar trigger source
// ------
module radar_trig_src (
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic fire,
  input wire logic pick,
  // trigger pins, low between pulses
  output logic trig_fwd,
  output logic trig_bwd
);
  logic [1:0] cnt_r = 2'h0;
  logic pick_r = 1'b0;
  // three cycles wide so the pin synchroniser cannot miss it
  always_ff @(posedge clk)
  begin
    if (fire)
    begin
      cnt_r <= 2'h3;
      pick_r <= pick;
    end
    else if (cnt_r != 2'h0)
      cnt_r <= cnt_r - 2'h1;
  end
  assign trig_fwd = (cnt_r != 2'h0) && !pick_r;
  assign trig_bwd = (cnt_r != 2'h0) && pick_r;
endmodule : radar_trig_src

// ---- verif/test_radar_scan_interscan_timing.sv ----
`timescale 1ns/10ps
module test_radar_scan_interscan_timing;
  import scan_timing_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dout;
  logic [31:0] rd;
  logic fire = 1'b0;
  logic pick = 1'b0;
  logic ls = 1'b0;
  logic ack, tf, tb, se, bl, beg, tbs, brs, tbg, tbg_n, brn, msw, isw, msh, ish;
  logic [15:0] sweep;
  logic [15:0] lf = 16'h52E3;
  logic [15:0] thr [4];
  logic tbg_at_br, brn_mid, brn_bl;
  int n_fail = 0;
  int checked = 0;
  int cyc_n = 0;
  int t_sw1, t_tb, t_br, t_se;
  int t_bl = 0;
  int n_se = 0;
  int n_beg = 0;
  int n_bl = 0;

  always #4 clk = ~clk;

  radar_trig_src u_src (.clk(clk), .fire(fire), .pick(pick), .trig_fwd(tf), .trig_bwd(tb));

  scan_timing u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .trig_fwd(tf), .trig_bwd(tb), .line_shift_on(ls), .sweep_level(sweep),
    .scan_end_pulse(se), .interscan_range_blank_pulse(bl), .interscan_begin_pulse(beg),
    .timebase_start_pulse(tbs), .brill_start_pulse(brs), .timebase_gate(tbg),
    .timebase_gate_n(tbg_n), .brill_enable_n(brn), .main_scan_sw(msw),
    .inter_scan_sw(isw), .main_scan_shift(msh), .inter_scan_shift(ish));

  // ------
  // helpers
  // ------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // timer reloads with the ratio and fires on the fall after it reaches zero, so every ratio+1 sweeps
  function automatic logic exp_begin(input int k);
    return (k % (int'(RATIO_MIN) + 1)) == 0;
  endfunction : exp_begin

  function automatic logic exp_inter(input int k);
    return (k % (int'(RATIO_MIN) + 1)) == 1;
  endfunction : exp_inter

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // waits for ack however long it takes; only the watchdog ends a hung transfer
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    rd = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // ------
  // event monitor
  // ------
  always @(posedge clk)
  begin
    cyc_n++;
    if (sweep === 16'h0001)
      t_sw1 = cyc_n;
    if (tbs === 1'b1)
      t_tb = cyc_n;
    if (brs === 1'b1)
    begin
      t_br = cyc_n;
      tbg_at_br = tbg;
    end
    if (se === 1'b1)
    begin
      t_se = cyc_n;
      n_se++;
    end
    if (beg === 1'b1)
      n_beg++;
    if (bl === 1'b1)
    begin
      t_bl = cyc_n;
      n_bl++;
    end
    if (cyc_n == t_br + 3)
      brn_mid = brn;
    if (cyc_n == t_bl + 2)
      brn_bl = brn;
  end

  task automatic run_sweep(input int k, input int s);
    int s0, b0, l0, w;
    logic lsv;
    s0 = n_se;
    b0 = n_beg;
    l0 = n_bl;
    lf = lfsr_next(lf);
    lsv = (k == 0) || (k != 16 && lf[1]);
    @(posedge clk);
    ls <= lsv;
    fire <= 1'b1;
    pick <= lf[0];
    @(posedge clk);
    fire <= 1'b0;
    w = 0;
    while (n_se == s0 && w < 1000)
    begin
      @(posedge clk);
      w++;
    end
    repeat (4) @(posedge clk);
    check(t_se - t_sw1, 32'(thr[s]));
    check(t_br - t_tb, TB_LEAD_CYC);
    check(tbg_at_br, 1'b1);
    check(brn_mid, 1'b0);
    check(n_se - s0, 1);
    check(n_beg - b0, exp_begin(k));
    check(n_bl - l0, exp_inter(k));
    if (exp_inter(k))
      check(brn_bl, 1'b1);
    check(32'(sweep), 0);
    check({tbg, tbg_n, brn}, 3'h3);
    check({isw, msw}, {exp_begin(k), !exp_begin(k)});
    check({ish, msh}, {exp_begin(k) & lsv, !(exp_begin(k) & lsv)});
  endtask : run_sweep

  // a second trigger before the first sweep ends cuts it with no scan end
  task automatic cut_sweep();
    int s0;
    s0 = n_se;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (20) @(posedge clk);
    check(32'(sweep != 16'h0000), 1);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(sweep), 0);
    check(n_se - s0, 0);
  endtask : cut_sweep

  // ------
  // main sequence
  // ------
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    check({msw, isw, tbg_n, brn}, 4'hB);
    wb(1'b0, OFS_MAX_RANGE0, 32'h0);
    check(rd, 32'(MAX_RANGE_DEF));
    wb(1'b0, OFS_BLANK_RANGE, 32'h0);
    check(rd, 32'(BLANK_RANGE_DEF));
    wb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, OFS_TB_DELAY, 32'h0);
    check(rd, TB_DELAY_DEF_CYC);
    wb(1'b0, 8'hFC, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, OFS_RATIO, 32'h05);
    wb(1'b0, OFS_RATIO, 32'h0);
    check(rd, 32'(RATIO_MIN));
    wb(1'b1, OFS_RATIO, 32'hC8);
    wb(1'b0, OFS_RATIO, 32'h0);
    check(rd, 32'(RATIO_MAX));
    wb(1'b1, OFS_RATIO, 32'(RATIO_MIN));
    wb(1'b1, OFS_BLANK_RANGE, 32'h96);
    for (int i = 0; i < 4; i++)
    begin
      lf = lfsr_next(lf);
      thr[i] = 16'(160 + 16 * i) + 16'(lf[3:0]);
      wb(1'b1, OFS_MAX_RANGE0 + 8'(4 * i), 32'(thr[i]));
    end
    wb(1'b0, OFS_MAX_RANGE3, 32'h0);
    check(rd, 32'(thr[3]));
    for (int k = 0; k < 21; k++)
    begin
      if (k >= 18)
        wb(1'b1, OFS_CTRL, 32'(k - 17));
      run_sweep(k, (k < 18) ? 0 : k - 17);
    end
    cut_sweep();
    conclude();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule : test_radar_scan_interscan_timing
